// ==== rtl/eso_consts.svh ====
`ifndef ESO_CONSTS_SVH
`define ESO_CONSTS_SVH
// frame layout
`define ESO_MAC_HDR_LEN   14
`define ESO_TYPE_POS      12
`define ESO_FCS_LEN       4
`define ESO_VLAN_TAG_LEN  4
`define ESO_SNAP_LEN      8
`define ESO_MAX_TAGS      2
`define ESO_ETYPE_MIN     16'h0600
`define ESO_TPID_RESET    16'h8100
`define ESO_APPEND_LEN    2
// command word and preamble fields
`define ESO_CK_BIT        14
`define ESO_FS_BIT        13
`define ESO_PRE_LEN       4
`define ESO_SSP_MSB       11
`define ESO_SSP_LSB       0
`define ESO_LOC_MSB       27
`define ESO_LOC_LSB       16
`endif

// ==== rtl/eso_pkg.sv ====
package eso_pkg;
  typedef struct packed {
    logic [7:0] data;
    logic       last;
  } eso_beat_t;
  typedef enum logic [1:0] {
    RX_PASS = 2'b00,
    RX_APLO = 2'b01,
    RX_APHI = 2'b10
  } eso_rx_state_t;
  typedef enum logic [1:0] {
    TX_LOAD = 2'b00,
    TX_PLAY = 2'b01,
    TX_WAIT = 2'b10
  } eso_tx_state_t;
endpackage

// ==== rtl/eso_sum_offload.sv ====
`timescale 1ns/1ns
`include "eso_consts.svh"
// Functional notes
// - mode zero sums bytes after the 14-byte header, before the FCS
// - mode one skips VLAN tags and SNAP, summing from layer-3 start
// - a VLAN tag is a type equal to the programmable tag identifier
// - two tags at most; a third identifier acts as type
// - enabled receive appends the sum after the last byte; length grows two
// - enable turns receive sum on, mode picks zero or one; else pass-through
// - sum in 16-bit units; odd final byte padded with a zero upper half
// - later byte is the upper half; every carry is folded back in
// - transmit sum is written into the stream on its way to the MAC
// - transmit sum only when request, first segment and enable all set
// - transmit summing starts at preamble bits 11:0, through the last byte
// - sum overwrites two bytes at preamble bits 27:16; other bits reserved
// - without the request bit the packet passes unmodified
// - preamble is not sent; host still counts its four bytes in length
// - transmit uses the same arithmetic and inserts the ones complement
module eso_sum_offload #(
  parameter int TX_DEPTH = 2048,
  parameter int LEN_W    = 14
) (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // control
  input  wire logic               rx_sum_enable,
  input  wire logic               rx_sum_mode_select,
  input  wire logic [15:0]        vlan_tag_id,
  input  wire logic               tx_sum_enable,
  // receive from MAC
  input  wire eso_pkg::eso_beat_t rx_in,
  input  wire logic               rx_in_valid,
  output logic                    rx_in_ready,
  // receive toward data FIFO
  output eso_pkg::eso_beat_t      rx_out,
  output logic                    rx_out_valid,
  input  wire logic               rx_out_ready,
  output logic [LEN_W-1:0]        rx_status_len,
  output logic                    rx_status_valid,
  // transmit from data FIFO
  input  wire logic [31:0]        tx_cmd_a,
  input  wire logic [31:0]        tx_cmd_b,
  input  wire eso_pkg::eso_beat_t tx_in,
  input  wire logic               tx_in_valid,
  output logic                    tx_in_ready,
  // transmit toward MAC
  output eso_pkg::eso_beat_t      tx_out,
  output logic                    tx_out_valid,
  input  wire logic               tx_out_ready
);
  localparam int AW = $clog2(TX_DEPTH);

  initial begin
    if (TX_DEPTH < 64 || TX_DEPTH > 4096 || (1 << AW) != TX_DEPTH)
      $error("TX_DEPTH must be a power of two from 64 to 4096");
    if (LEN_W < 12 || LEN_W > 16)
      $error("LEN_W must be 12 to 16");
  end

  // end-around carry add
  function automatic logic [15:0] fold_add(input logic [15:0] a, input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[15:0] + {15'h0000, s[16]};
  endfunction

  // ==========================================================
  // reset synchroniser
  logic rst_m;
  logic rst_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_m <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_m <= 1'b1;
      rst_q <= rst_m;
    end
  end

  // ==========================================================
  // receive: frame position and header parser
  eso_pkg::eso_rx_state_t rx_st;
  eso_pkg::eso_rx_state_t next_rx_st;
  logic                   rx_acc;
  logic [LEN_W-1:0]       rx_pos;
  logic [LEN_W-1:0]       rx_tpos;
  logic [LEN_W-1:0]       rx_start;
  logic                   rx_start_ok;
  logic [1:0]             rx_tags;
  logic [7:0]             rx_thi;
  logic                   rx_on;

  assign rx_acc = rx_in_valid && rx_in_ready;
  assign rx_on  = rx_sum_enable;

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_pos      <= '0;
      rx_tpos     <= LEN_W'(`ESO_TYPE_POS);
      rx_start    <= '0;
      rx_start_ok <= 1'b0;
      rx_tags     <= 2'h0;
      rx_thi      <= 8'h00;
    end else if (rx_acc && rx_in.last) begin
      rx_pos      <= '0;
      rx_tpos     <= LEN_W'(`ESO_TYPE_POS);
      rx_start_ok <= 1'b0;
      rx_tags     <= 2'h0;
    end else if (rx_acc) begin
      rx_pos <= rx_pos + 1'b1;
      if (!rx_sum_mode_select) begin
        rx_start    <= LEN_W'(`ESO_MAC_HDR_LEN);
        rx_start_ok <= 1'b1;
      end else if (rx_pos == rx_tpos) begin
        rx_thi <= rx_in.data;
      end else if (rx_pos == rx_tpos + 1'b1 && !rx_start_ok) begin
        if ({rx_thi, rx_in.data} == vlan_tag_id && rx_tags < 2'(`ESO_MAX_TAGS)) begin
          rx_tags <= rx_tags + 1'b1;
          rx_tpos <= rx_tpos + LEN_W'(`ESO_VLAN_TAG_LEN);
        end else if ({rx_thi, rx_in.data} < `ESO_ETYPE_MIN) begin
          rx_start    <= rx_tpos + LEN_W'(2 + `ESO_SNAP_LEN);
          rx_start_ok <= 1'b1;
        end else begin
          rx_start    <= rx_tpos + LEN_W'(2);
          rx_start_ok <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // receive: sum, delayed by four bytes so the FCS stays out
  logic [7:0]       rx_hist [4];
  logic [15:0]      rx_sum;
  logic             rx_odd;
  logic [7:0]       rx_lo;
  logic [15:0]      rx_fin;
  logic [LEN_W-1:0] rx_dpos;
  logic             rx_take;
  logic [15:0]      next_rx_sum;
  logic             next_rx_odd;
  logic [7:0]       next_rx_lo;

  assign rx_dpos = rx_pos - LEN_W'(`ESO_FCS_LEN);
  assign rx_take = rx_acc && rx_pos >= LEN_W'(`ESO_FCS_LEN) && rx_start_ok && rx_dpos >= rx_start;

  always_comb begin
    next_rx_sum = rx_sum;
    next_rx_odd = rx_odd;
    next_rx_lo  = rx_lo;
    if (rx_take) begin
      next_rx_odd = !rx_odd;
      if (rx_odd)
        next_rx_sum = fold_add(rx_sum, {rx_hist[3], rx_lo});
      else
        next_rx_lo = rx_hist[3];
    end
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      for (int i = 0; i < 4; i++)
        rx_hist[i] <= 8'h00;
      rx_sum <= 16'h0000;
      rx_odd <= 1'b0;
      rx_lo  <= 8'h00;
      rx_fin <= 16'h0000;
    end else if (rx_acc) begin
      rx_hist[0] <= rx_in.data;
      for (int i = 1; i < 4; i++)
        rx_hist[i] <= rx_hist[i-1];
      if (rx_in.last) begin
        rx_sum <= 16'h0000;
        rx_odd <= 1'b0;
        rx_fin <= next_rx_odd ? fold_add(next_rx_sum, {8'h00, next_rx_lo}) : next_rx_sum;
      end else begin
        rx_sum <= next_rx_sum;
        rx_odd <= next_rx_odd;
        rx_lo  <= next_rx_lo;
      end
    end
  end

  // ==========================================================
  // receive: two-entry output buffer, entry 0 is the output
  eso_pkg::eso_beat_t rx_buf [2];
  eso_pkg::eso_beat_t rx_push_beat;
  logic [1:0]         rx_cnt;
  logic [1:0]         next_rx_cnt;
  logic               rx_push;
  logic               rx_pop;

  assign rx_pop = rx_out_valid && rx_out_ready;

  always_comb begin
    next_rx_st   = rx_st;
    rx_push      = 1'b0;
    rx_push_beat = rx_in;
    unique case (rx_st)
      eso_pkg::RX_PASS: begin
        rx_push = rx_acc;
        if (rx_acc && rx_in.last && rx_on) begin
          rx_push_beat.last = 1'b0;
          next_rx_st        = eso_pkg::RX_APLO;
        end
      end
      eso_pkg::RX_APLO: begin
        rx_push      = rx_cnt < 2'h2 || rx_pop;
        rx_push_beat = '{data: rx_fin[7:0], last: 1'b0};
        if (rx_push)
          next_rx_st = eso_pkg::RX_APHI;
      end
      eso_pkg::RX_APHI: begin
        rx_push      = rx_cnt < 2'h2 || rx_pop;
        rx_push_beat = '{data: rx_fin[15:8], last: 1'b1};
        if (rx_push)
          next_rx_st = eso_pkg::RX_PASS;
      end
      default: next_rx_st = eso_pkg::RX_PASS;
    endcase
    next_rx_cnt = rx_cnt + {1'b0, rx_push} - {1'b0, rx_pop};
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_st        <= eso_pkg::RX_PASS;
      rx_cnt       <= 2'h0;
      rx_buf[0]    <= '0;
      rx_buf[1]    <= '0;
      rx_in_ready  <= 1'b0;
      rx_out_valid <= 1'b0;
    end else begin
      rx_st        <= next_rx_st;
      rx_cnt       <= next_rx_cnt;
      rx_out_valid <= next_rx_cnt != 2'h0;
      // registered ready: a count of one or less leaves room for one more
      rx_in_ready  <= next_rx_st == eso_pkg::RX_PASS && next_rx_cnt <= 2'h1;
      if (rx_pop)
        rx_buf[0] <= rx_buf[1];
      if (rx_push)
        rx_buf[(rx_cnt == 2'h0 || (rx_cnt == 2'h1 && rx_pop)) ? 0 : 1] <= rx_push_beat;
    end
  end
  assign rx_out = rx_buf[0];

  // receive length status
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      rx_status_len   <= '0;
      rx_status_valid <= 1'b0;
    end else begin
      rx_status_valid <= rx_acc && rx_in.last;
      if (rx_acc && rx_in.last)
        rx_status_len <= rx_pos + 1'b1 + (rx_on ? LEN_W'(`ESO_APPEND_LEN) : LEN_W'(0));
    end
  end

  // ==========================================================
  // transmit: store and forward with sum and insertion
  eso_pkg::eso_tx_state_t tx_st;
  logic [7:0]             tx_mem [TX_DEPTH];
  logic [AW:0]            tx_wr;
  logic [AW:0]            tx_rd;
  logic [1:0]             tx_pre_cnt;
  logic [31:0]            tx_pre;
  logic                   tx_do;
  logic                   tx_first;
  logic [15:0]            tx_sum;
  logic                   tx_odd;
  logic [7:0]             tx_lo;
  logic [15:0]            tx_fin;
  logic                   tx_acc;
  logic                   tx_data_acc;
  logic                   tx_take;
  logic [11:0]            tx_loc;
  logic                   tx_adv;
  logic [15:0]            next_tx_sum;
  logic                   tx_req;

  assign tx_acc      = tx_in_valid && tx_in_ready;
  assign tx_req      = tx_cmd_b[`ESO_CK_BIT] && tx_cmd_a[`ESO_FS_BIT] && tx_sum_enable;
  // the first preamble byte arrives before tx_do is set, so it is judged from the commands
  assign tx_data_acc = tx_acc && !(tx_first ? tx_req : (tx_do && tx_pre_cnt != 2'h0));
  assign tx_take     = tx_data_acc && tx_do && tx_wr >= (AW+1)'(tx_pre[`ESO_SSP_MSB:`ESO_SSP_LSB]);
  assign tx_loc      = tx_pre[`ESO_LOC_MSB:`ESO_LOC_LSB];
  assign tx_adv      = tx_st == eso_pkg::TX_PLAY && (!tx_out_valid || tx_out_ready);
  assign next_tx_sum = (tx_take && tx_odd) ? fold_add(tx_sum, {tx_in.data, tx_lo}) : tx_sum;

  always_ff @(posedge clk) begin
    if (tx_data_acc)
      tx_mem[tx_wr[AW-1:0]] <= tx_in.data;
  end

  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      tx_st       <= eso_pkg::TX_LOAD;
      tx_wr       <= '0;
      tx_rd       <= '0;
      tx_pre_cnt  <= 2'h0;
      tx_pre      <= 32'h00000000;
      tx_do       <= 1'b0;
      tx_first    <= 1'b1;
      tx_sum      <= 16'h0000;
      tx_odd      <= 1'b0;
      tx_lo       <= 8'h00;
      tx_fin      <= 16'h0000;
      tx_in_ready <= 1'b0;
    end else begin
      unique case (tx_st)
        eso_pkg::TX_LOAD: begin
          tx_in_ready <= !(tx_acc && tx_in.last) && tx_wr < (AW+1)'(TX_DEPTH - 1);
          if (tx_acc && tx_first) begin
            tx_first <= 1'b0;
            // all three set, else the packet passes untouched
            tx_do <= tx_cmd_b[`ESO_CK_BIT] && tx_cmd_a[`ESO_FS_BIT] && tx_sum_enable;
            if (tx_cmd_b[`ESO_CK_BIT] && tx_cmd_a[`ESO_FS_BIT] && tx_sum_enable) begin
              tx_pre     <= {24'h000000, tx_in.data};
              tx_pre_cnt <= 2'h3;
            end
          end else if (tx_acc && tx_do && tx_pre_cnt != 2'h0) begin
            tx_pre     <= tx_pre | ({24'h000000, tx_in.data} << (8 * (4 - tx_pre_cnt)));
            tx_pre_cnt <= tx_pre_cnt - 1'b1;
          end
          if (tx_data_acc)
            tx_wr <= tx_wr + 1'b1;
          if (tx_take) begin
            tx_odd <= !tx_odd;
            tx_lo  <= tx_in.data;
            tx_sum <= next_tx_sum;
          end
          if (tx_acc && tx_in.last) begin
            // through the last byte, odd tail padded with zero
            tx_fin <= ~((tx_take ? !tx_odd : tx_odd)
                        ? fold_add(next_tx_sum, {8'h00, tx_take ? tx_in.data : tx_lo})
                        : next_tx_sum);
            tx_rd  <= '0;
            tx_st  <= eso_pkg::TX_PLAY;
          end
        end
        eso_pkg::TX_PLAY: begin
          tx_in_ready <= 1'b0;
          if (tx_adv)
            tx_rd <= tx_rd + 1'b1;
          if (tx_adv && tx_rd + 1'b1 == tx_wr)
            tx_st <= eso_pkg::TX_WAIT;
        end
        eso_pkg::TX_WAIT: begin
          if (tx_out_ready || !tx_out_valid) begin
            tx_st       <= eso_pkg::TX_LOAD;
            tx_wr       <= '0;
            tx_first    <= 1'b1;
            tx_do       <= 1'b0;
            tx_pre_cnt  <= 2'h0;
            tx_sum      <= 16'h0000;
            tx_odd      <= 1'b0;
            tx_in_ready <= 1'b1;
          end
        end
        default: tx_st <= eso_pkg::TX_LOAD;
      endcase
    end
  end

  // transmit output register
  always_ff @(posedge clk or negedge rst_q) begin
    if (!rst_q) begin
      tx_out       <= '0;
      tx_out_valid <= 1'b0;
    end else if (tx_adv) begin
      tx_out_valid <= 1'b1;
      tx_out.last  <= tx_rd + 1'b1 == tx_wr;
      if (tx_do && tx_rd == (AW+1)'(tx_loc))
        tx_out.data <= tx_fin[7:0];
      else if (tx_do && tx_rd == (AW+1)'(tx_loc) + 1'b1)
        tx_out.data <= tx_fin[15:8];
      else
        tx_out.data <= tx_mem[tx_rd[AW-1:0]];
    end else if (tx_out_ready) begin
      tx_out_valid <= 1'b0;
    end
  end

  // ==========================================================
  // checks
  sequence s_rx_end_on;
    rx_acc && rx_in.last && rx_on && rx_st == eso_pkg::RX_PASS;
  endsequence
  sequence s_append_done;
    rx_st == eso_pkg::RX_APHI && rx_push;
  endsequence

  a_rx_append_seq: assert property (@(posedge clk) disable iff (!rst_q)
    s_rx_end_on |=> rx_st == eso_pkg::RX_APLO ##[0:40] s_append_done)
    else $error("sum bytes not appended after frame end");
  a_rx_len_grow: assert property (@(posedge clk) disable iff (!rst_q)
    s_rx_end_on |=> rx_status_valid && rx_status_len == $past(rx_pos) + LEN_W'(3))
    else $error("length not grown by two");
  a_rx_pass_len: assert property (@(posedge clk) disable iff (!rst_q)
    rx_acc && rx_in.last && !rx_on |=> rx_st == eso_pkg::RX_PASS && rx_status_len == $past(rx_pos) + 1'b1)
    else $error("disabled receive altered the frame");
  a_rx_mode0_hdr: assert property (@(posedge clk) disable iff (!rst_q)
    rx_take && !rx_sum_mode_select |-> rx_dpos >= LEN_W'(`ESO_MAC_HDR_LEN))
    else $error("header byte summed in mode zero");
  a_rx_tag_limit: assert property (@(posedge clk) disable iff (!rst_q)
    rx_tags <= 2'(`ESO_MAX_TAGS))
    else $error("more than two tags skipped");
  a_rx_fcs_out: assert property (@(posedge clk) disable iff (!rst_q)
    rx_take |-> rx_pos >= LEN_W'(`ESO_FCS_LEN))
    else $error("byte summed before it is known not FCS");
  a_tx_no_request: assert property (@(posedge clk) disable iff (!rst_q)
    tx_acc && tx_first && !tx_cmd_b[`ESO_CK_BIT] |=> !tx_do && tx_pre_cnt == 2'h0)
    else $error("packet without request was processed");
  a_tx_pre_drop: assert property (@(posedge clk) disable iff (!rst_q)
    tx_acc && tx_first && tx_cmd_b[`ESO_CK_BIT] && tx_cmd_a[`ESO_FS_BIT] && tx_sum_enable
    |=> tx_wr == $past(tx_wr))
    else $error("preamble byte stored for transmission");
  a_tx_insert: assert property (@(posedge clk) disable iff (!rst_q)
    tx_adv && tx_do && tx_rd == (AW+1)'(tx_loc) |=> tx_out.data == tx_fin[7:0])
    else $error("sum not inserted at location");
  a_tx_hold: assert property (@(posedge clk) disable iff (!rst_q)
    tx_out_valid && !tx_out_ready |=> tx_out_valid && $stable(tx_out))
    else $error("transmit output changed while stalled");
endmodule

// ==== tb/eso_host_model.sv ====
`timescale 1ns/1ns
// ====================================================================
// host side: writes transmit packets, drains the receive FIFO
module eso_host_model (
  // clock
  input  wire logic               clk,
  // transmit data into the block
  output logic [31:0]             tx_cmd_a,
  output logic [31:0]             tx_cmd_b,
  output eso_pkg::eso_beat_t      tx_in,
  output logic                    tx_in_valid,
  input  wire logic               tx_in_ready,
  // receive data out of the block
  input  wire eso_pkg::eso_beat_t rx_out,
  input  wire logic               rx_out_valid,
  output logic                    rx_out_ready,
  input  wire logic               hold
);
  logic [8:0] rxq[$];

  initial begin
    tx_cmd_a = '0;
    tx_cmd_b = '0;
    tx_in = '0;
    tx_in_valid = 1'b0;
    rx_out_ready = 1'b0;
  end

  // slow reader: random gaps, full stop while hold is up
  always @(posedge clk) begin
    if (rx_out_valid && rx_out_ready)
      rxq.push_back(rx_out);
    rx_out_ready <= !hold && ($urandom_range(3) != 0);
  end

  // commands stay put for the whole packet, preamble leads the data
  task automatic send(input logic [7:0] p[$], input logic [31:0] a, input logic [31:0] b);
    int i;
    i = 0;
    tx_cmd_a <= a;
    tx_cmd_b <= b;
    while (i < p.size()) begin
      tx_in_valid <= 1'b1;
      tx_in <= {p[i], i == p.size() - 1};
      @(posedge clk);
      if (tx_in_ready)
        i++;
    end
    tx_in_valid <= 1'b0;
    // released data must not look like the last byte
    tx_in <= {~p[p.size() - 1], 1'b0};
    @(posedge clk);
  endtask
endmodule

// ==== tb/eso_sum_offload_tb.sv ====
`timescale 1ns/1ns
module eso_sum_offload_tb;
  // ====================================================================
  // wiring
  logic               clk                = 1'b0;
  logic               rst_n              = 1'b0;
  logic               rx_sum_enable      = 1'b0;
  logic               rx_sum_mode_select = 1'b0;
  logic [15:0]        vlan_tag_id        = 16'h8100;
  logic               tx_sum_enable      = 1'b0;
  eso_pkg::eso_beat_t rx_in              = '0;
  logic               rx_in_valid        = 1'b0;
  logic               tx_out_ready       = 1'b0;
  logic               hold               = 1'b0;
  logic               rx_in_ready;
  eso_pkg::eso_beat_t rx_out;
  logic               rx_out_valid;
  logic               rx_out_ready;
  logic [13:0]        rx_status_len;
  logic               rx_status_valid;
  logic [31:0]        tx_cmd_a;
  logic [31:0]        tx_cmd_b;
  eso_pkg::eso_beat_t tx_in;
  logic               tx_in_valid;
  logic               tx_in_ready;
  eso_pkg::eso_beat_t tx_out;
  logic               tx_out_valid;
  logic [8:0]         txq[$];
  logic [13:0]        lenq[$];
  logic [7:0]         f[$];
  int                 n_errors           = 0;
  int                 comparisons        = 0;

  always #5 clk = ~clk;

  eso_sum_offload #(.TX_DEPTH(128), .LEN_W(14)) dut_u (
    .clk(clk), .rst_n(rst_n), .rx_sum_enable(rx_sum_enable), .rx_sum_mode_select(rx_sum_mode_select),
    .vlan_tag_id(vlan_tag_id), .tx_sum_enable(tx_sum_enable), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_out(rx_out), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .rx_status_len(rx_status_len), .rx_status_valid(rx_status_valid), .tx_cmd_a(tx_cmd_a),
    .tx_cmd_b(tx_cmd_b), .tx_in(tx_in), .tx_in_valid(tx_in_valid), .tx_in_ready(tx_in_ready),
    .tx_out(tx_out), .tx_out_valid(tx_out_valid), .tx_out_ready(tx_out_ready));

  eso_host_model host_u (
    .clk(clk), .tx_cmd_a(tx_cmd_a), .tx_cmd_b(tx_cmd_b), .tx_in(tx_in), .tx_in_valid(tx_in_valid),
    .tx_in_ready(tx_in_ready), .rx_out(rx_out), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
    .hold(hold));

  // MAC side of transmit stalls at random
  always @(posedge clk) begin
    if (tx_out_valid && tx_out_ready)
      txq.push_back(tx_out);
    if (rx_status_valid)
      lenq.push_back(rx_status_len);
    tx_out_ready <= $urandom_range(3) != 0;
  end

  // ====================================================================
  // reference arithmetic
  function automatic logic [15:0] osum(input logic [7:0] q[$], input int s, input int e);
    logic [16:0] a;
    a = '0;
    for (int i = s; i < e; i += 2) begin
      a = a[15:0] + {(i + 1 < e) ? q[i + 1] : 8'h00, q[i]};
      a = a[15:0] + a[16];
    end
    return a[15:0];
  endfunction

  function automatic int l3_start(input logic [7:0] q[$], input logic [15:0] tid);
    int p;
    p = 12;
    for (int k = 0; k < 2 && {q[p], q[p + 1]} == tid; k++)
      p += 4;
    return ({q[p], q[p + 1]} < 16'h0600) ? p + 10 : p + 2;
  endfunction

  function automatic void mk(ref logic [7:0] q[$], input int n);
    q.delete();
    repeat (n) q.push_back(8'($urandom));
  endfunction

  // ====================================================================
  // checks and run control
  task automatic miss(input string m);
    n_errors++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  task automatic cmp_q(input logic [8:0] got[$], input logic [8:0] exp[$]);
    comparisons++;
    if (got.size() != exp.size())
      miss($sformatf("stream length %0d, expected %0d", got.size(), exp.size()));
    else
      foreach (exp[i])
        if (got[i] !== exp[i])
          miss($sformatf("byte %0d is %h, expected %h", i, got[i], exp[i]));
  endtask

  task automatic cmp_len(input logic [13:0] got, input logic [13:0] exp);
    comparisons++;
    if (got !== exp)
      miss($sformatf("status length %h, expected %h", got, exp));
  endtask

  task automatic cmp_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp)
      miss($sformatf("flag %b, expected %b", got, exp));
  endtask

  task automatic wait_both(input int nr, input int nt);
    for (int k = 0; k < 3000; k++) begin
      if (host_u.rxq.size() >= nr && txq.size() >= nt)
        break;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
  endtask

  task automatic test_done;
    $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // ====================================================================
  // receive path
  task automatic rx_send(input logic [7:0] q[$]);
    int i;
    i = 0;
    while (i < q.size()) begin
      rx_in_valid <= 1'b1;
      rx_in <= {q[i], i == q.size() - 1};
      @(posedge clk);
      if (rx_in_ready)
        i++;
    end
    rx_in_valid <= 1'b0;
    rx_in <= {~q[q.size() - 1], 1'b0};
    @(posedge clk);
  endtask

  // stl > 0 blocks the reader that long, so the buffer must refuse
  task automatic rx_run(input logic en, input logic md, input logic [15:0] tid, input int stl);
    logic [8:0]  e[$];
    logic [15:0] s;
    int          n;
    n = f.size();
    // pad stripping lives outside; controls move only between frames
    rx_sum_enable <= en;
    rx_sum_mode_select <= md;
    vlan_tag_id <= tid;
    @(posedge clk);
    s = osum(f, md ? l3_start(f, tid) : 14, n - 4);
    foreach (f[i])
      e.push_back({f[i], !en && i == n - 1});
    if (en) begin
      e.push_back({s[7:0], 1'b0});
      e.push_back({s[15:8], 1'b1});
    end
    host_u.rxq.delete();
    lenq.delete();
    fork
      rx_send(f);
      if (stl > 0) begin
        hold <= 1'b1;
        repeat (stl) @(posedge clk);
        cmp_bit(rx_in_ready, 1'b0);
        hold <= 1'b0;
      end
    join
    wait_both(e.size(), 0);
    cmp_q(host_u.rxq, e);
    cmp_len(lenq.size() == 1 ? lenq[0] : 14'bx, 14'(n + (en ? 2 : 0)));
  endtask

  // ====================================================================
  // transmit path
  task automatic tx_run(input logic en, input logic ck, input logic fs);
    logic [7:0]  p[$];
    logic [7:0]  d[$];
    logic [8:0]  e[$];
    logic [15:0] s;
    logic [31:0] pre;
    int          n;
    int          ssp;
    int          loc;
    n = 20 + $urandom_range(40);
    mk(d, n);
    ssp = 14 + $urandom_range(n - 19);
    loc = 14 + $urandom_range(n - 20);
    // reserved preamble bits set on purpose, they must be ignored
    pre = {4'hA, 12'(loc), 4'h5, 12'(ssp)};
    p = d;
    if (en && ck && fs) begin
      for (int b = 3; b >= 0; b--)
        p.push_front(pre[8 * b +: 8]);
      s = ~osum(d, ssp, n);
      d[loc] = s[7:0];
      d[loc + 1] = s[15:8];
    end
    foreach (d[i])
      e.push_back({d[i], i == n - 1});
    tx_sum_enable <= en;
    @(posedge clk);
    txq.delete();
    host_u.send(p, {18'h0, fs, 13'h0}, {17'h0, ck, 14'h0});
    wait_both(0, n);
    cmp_q(txq, e);
  endtask

  // ====================================================================
  // main sequence
  initial begin
    void'($urandom(32'hAC2F));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    // shortest frames first: empty and one-byte sum
    for (int i = 0; i < 8; i++) begin
      mk(f, i < 2 ? 18 + i : 20 + $urandom_range(44));
      rx_run(1'b1, 1'b0, 16'h8100, i == 7 ? 30 : 0);
    end
    $display("test rx mode zero done");
    for (int t = 0; t < 4; t++)
      for (int sn = 0; sn < 2; sn++) begin
        mk(f, 40 + $urandom_range(1));
        vlan_tag_id <= t[0] ? 16'h88A8 : 16'h8100;
        for (int j = 0; j < t; j++)
          {f[12 + 4 * j], f[13 + 4 * j]} = t[0] ? 16'h88A8 : 16'h8100;
        {f[12 + 4 * t], f[13 + 4 * t]} = sn ? 16'h002E : 16'h0800;
        rx_run(1'b1, 1'b1, t[0] ? 16'h88A8 : 16'h8100, 0);
      end
    $display("test rx mode one done");
    for (int i = 0; i < 2; i++) begin
      mk(f, 25 + i);
      rx_run(1'b0, i[0], 16'h8100, 0);
    end
    $display("test rx disabled done");
    for (int i = 0; i < 11; i++)
      tx_run(i > 7 || i[2], i > 7 || i[1], i > 7 || i[0]);
    $display("test tx done");
    test_done;
  end

  initial begin
    #400000;
    miss("watchdog expired");
    test_done;
  end
endmodule
